//--- rtl/sbpi_pkg.sv
// Constants, types and helpers shared by the system bus pin interface
package sbpi_pkg;

    localparam int SYS_HZ = 125_000_000;
    localparam int SYS_MHZ = 125;
    localparam int CARD_CLK_HZ = 8_000_000;

    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int CHIP_W = 2;
    localparam int SEL_W = 4;
    localparam int BE_W = 2;
    localparam int CNT_W = 8;
    localparam int ACC_W = 28;

    localparam int BE_HI = 1;
    localparam int BE_LO = 0;

    // DRAM row comes from the upper address bits, column from the lower ones
    localparam int ROW_SHIFT = 10;
    localparam logic [ADDR_W-1:0] COL_MASK = 21'h0003ff;

    // Phase times in ns
    localparam int SETUP_NS = 30;
    localparam int STROBE_NS = 120;
    localparam int CAS_NS = 60;
    localparam int HOLD_NS = 16;

    // Least times round up to whole cycles
    function automatic int sbpiCycles(input int ns);
        sbpiCycles = (ns * SYS_MHZ + 999) / 1000;
        if (sbpiCycles < 1) begin
            sbpiCycles = 1;
        end
    endfunction : sbpiCycles

    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(sbpiCycles(SETUP_NS) - 1);
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(sbpiCycles(STROBE_NS) - 1);
    localparam logic [CNT_W-1:0] CAS_LAST = CNT_W'(sbpiCycles(CAS_NS) - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(sbpiCycles(HOLD_NS) - 1);

    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * CARD_CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(SYS_HZ);

    localparam logic [SEL_W-1:0] SEL_NONE = 4'hf;
    localparam logic [SEL_W-1:0] SEL_ONE = 4'h1;

    typedef enum logic [2:0] {
        TGT_DRAM = 3'h0,
        TGT_ROM = 3'h1,
        TGT_LCD = 3'h2,
        TGT_CARD_IO = 3'h3,
        TGT_CARD_MEM = 3'h4
    } sbpi_target_e;

    // Gray sequence idle -> setup -> active -> finish -> idle
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_ACTIVE = 3'h3,
        ST_FINISH = 3'h2
    } sbpi_state_e;

    function automatic logic sbpiTargetOk(input logic [2:0] t);
        sbpiTargetOk = (t <= TGT_CARD_MEM);
    endfunction : sbpiTargetOk

    // One-hot active-low select for a chip number
    function automatic logic [SEL_W-1:0] sbpiSelN(input logic [CHIP_W-1:0] chip);
        sbpiSelN = ~(SEL_ONE << chip);
    endfunction : sbpiSelN

endpackage : sbpi_pkg

//--- rtl/sbpi_clk_if.sv
// Carrier for the card clock between the divider and the bus interface
`timescale 1ns/1ns
`default_nettype none

interface sbpi_clk_if;
    logic cardClk;
    modport gen (output cardClk);
    modport sink (input cardClk);
endinterface : sbpi_clk_if

`default_nettype wire

//--- rtl/sbpi_card_clock.sv
// Card clock generator: fractional divider giving an exact 8 MHz average
`timescale 1ns/1ns
`default_nettype none

module sbpi_card_clock (
    input wire logic sys_clk,
    input wire logic rst_n,
    sbpi_clk_if.gen clkOut
);

    typedef struct packed {
        logic [sbpi_pkg::ACC_W-1:0] acc;
        logic clk;
    } sbpi_div_s;

    sbpi_div_s div_r;
    sbpi_div_s div_nxt;

    // 125/16 is not whole, so edges jitter by one cycle; the mean stays exact
    always_comb begin
        div_nxt = div_r;
        div_nxt.acc = div_r.acc + sbpi_pkg::ACC_STEP;
        if (div_nxt.acc >= sbpi_pkg::ACC_WRAP) begin
            div_nxt.acc = div_nxt.acc - sbpi_pkg::ACC_WRAP;
            div_nxt.clk = ~div_r.clk;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign clkOut.cardClk = div_r.clk;

endmodule : sbpi_card_clock

`default_nettype wire

//--- rtl/sbpi_bus_iface.sv
// System bus pin interface: sequences one access at a time to DRAM, ROM, LCD or card
// Function
// - Every active-low pin is asserted low, driven and sampled that way.
// - Drive a 21-bit address bus to DRAM, ROM, LCD and card controller.
// - 16-bit two-way data bus carries write data out and read data in.
// - Display select is asserted for the whole of an LCD access.
// - Display read strobe asserted only during LCD reads.
// - Shared write strobe writes LCD when selected, otherwise flash.
// - LCD access, or card access without zero-wait, does not complete before ready is seen.
// - Four ROM selects; only the addressed ROM's select is asserted.
// - ROM read strobe asserted only during ROM reads.
// - One of four row strobes asserted while the row address is out.
// - Upper/lower column strobe per DRAM half while column address is out.
// - DRAM write strobe asserted only during DRAM writes.
// - Supply a continuous 8 MHz clock to the card controller.
// - High-byte enable asserted when upper data byte is valid for card.
// - Card I/O read and write strobes for card I/O port accesses.
// - Card memory read and write strobes for card memory accesses.
// - Zero-wait input low ends a card access without further waits.
// - Card interrupt input is captured as an interrupt request.
// - Card reset output asserted while the card controller is reset.
`timescale 1ns/1ns
`default_nettype none

module sbpi_bus_iface (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [2:0] reqTarget,
    input wire logic reqWrite,
    input wire logic [sbpi_pkg::CHIP_W-1:0] reqChip,
    input wire logic [sbpi_pkg::BE_W-1:0] reqByteEn,
    input wire logic [sbpi_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [sbpi_pkg::DATA_W-1:0] reqData,
    output logic ackValid,
    output logic [sbpi_pkg::DATA_W-1:0] ackData,
    input wire logic cardResetReq,
    output logic cardIrqReq,
    output logic [sbpi_pkg::ADDR_W-1:0] busAddr,
    input wire logic [sbpi_pkg::DATA_W-1:0] busDataIn,
    output logic [sbpi_pkg::DATA_W-1:0] busDataOut,
    output logic busDataOe,
    output logic display_select_n,
    output logic display_read_strobe_n,
    output logic shared_write_strobe_n,
    input wire logic display_card_ready,
    output logic [sbpi_pkg::SEL_W-1:0] boot_mem_select_n,
    output logic boot_mem_read_strobe_n,
    output logic [sbpi_pkg::SEL_W-1:0] dram_row_strobe_n,
    output logic dram_col_strobe_hi_n,
    output logic dram_col_strobe_lo_n,
    output logic dram_write_strobe_n,
    output logic card_clock_out,
    output logic card_high_byte_en_n,
    output logic card_io_read_n,
    output logic card_io_write_n,
    output logic card_mem_read_n,
    output logic card_mem_write_n,
    input wire logic card_no_wait_n,
    input wire logic cardIrq,
    output logic card_reset_out
);

    typedef struct packed {
        sbpi_pkg::sbpi_state_e st;
        logic [sbpi_pkg::CNT_W-1:0] cnt;
        logic [2:0] tgt;
        logic write;
        logic [sbpi_pkg::CHIP_W-1:0] chip;
        logic [sbpi_pkg::BE_W-1:0] be;
        logic [sbpi_pkg::ADDR_W-1:0] addr;
        logic [sbpi_pkg::DATA_W-1:0] wdata;
        logic rdy;
        logic ackV;
        logic [sbpi_pkg::DATA_W-1:0] ackD;
        logic [sbpi_pkg::ADDR_W-1:0] addrOut;
        logic [sbpi_pkg::DATA_W-1:0] dOut;
        logic dOe;
        logic dispSelN;
        logic dispRdN;
        logic shWrN;
        logic [sbpi_pkg::SEL_W-1:0] romSelN;
        logic romRdN;
        logic [sbpi_pkg::SEL_W-1:0] rasN;
        logic ucasN;
        logic lcasN;
        logic dramWrN;
        logic cardClk;
        logic shbN;
        logic ioRdN;
        logic ioWrN;
        logic memRdN;
        logic memWrN;
        logic irqReq;
        logic cardRst;
    } sbpi_core_s;

    localparam sbpi_core_s CORE_RESET = '{
        st: sbpi_pkg::ST_IDLE,
        cnt: '0,
        tgt: '0,
        write: 1'b0,
        chip: '0,
        be: '0,
        addr: '0,
        wdata: '0,
        rdy: 1'b1,
        ackV: 1'b0,
        ackD: '0,
        addrOut: '0,
        dOut: '0,
        dOe: 1'b0,
        dispSelN: 1'b1,
        dispRdN: 1'b1,
        shWrN: 1'b1,
        romSelN: sbpi_pkg::SEL_NONE,
        romRdN: 1'b1,
        rasN: sbpi_pkg::SEL_NONE,
        ucasN: 1'b1,
        lcasN: 1'b1,
        dramWrN: 1'b1,
        cardClk: 1'b0,
        shbN: 1'b1,
        ioRdN: 1'b1,
        ioWrN: 1'b1,
        memRdN: 1'b1,
        memWrN: 1'b1,
        irqReq: 1'b0,
        cardRst: 1'b0
    };

    sbpi_core_s core_r;
    sbpi_core_s core_nxt;

    sbpi_clk_if cardClkBus ();

    sbpi_card_clock cardClockGen (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkOut(cardClkBus.gen)
    );

    always_comb begin
        logic finish;
        logic isDram;
        logic isRom;
        logic isLcd;
        logic isCio;
        logic isCmem;
        logic inAcc;
        logic strobe;
        logic rowPhase;
        finish = 1'b0;
        isDram = 1'b0;
        isRom = 1'b0;
        isLcd = 1'b0;
        isCio = 1'b0;
        isCmem = 1'b0;
        inAcc = 1'b0;
        strobe = 1'b0;
        rowPhase = 1'b0;
        core_nxt = core_r;
        core_nxt.ackV = 1'b0;
        core_nxt.cardClk = cardClkBus.cardClk;
        core_nxt.irqReq = cardIrq;
        core_nxt.cardRst = cardResetReq;

        case (core_r.st)
            sbpi_pkg::ST_IDLE: begin
                // Only one request in flight keeps the shared buses single-owner
                if (reqValid && sbpi_pkg::sbpiTargetOk(reqTarget)) begin
                    core_nxt.st = sbpi_pkg::ST_SETUP;
                    core_nxt.cnt = sbpi_pkg::SETUP_LAST;
                    core_nxt.tgt = reqTarget;
                    core_nxt.write = reqWrite;
                    core_nxt.chip = reqChip;
                    core_nxt.be = reqByteEn;
                    core_nxt.addr = reqAddr;
                    core_nxt.wdata = reqData;
                end
            end
            sbpi_pkg::ST_SETUP: begin
                if (core_r.cnt == '0) begin
                    core_nxt.st = sbpi_pkg::ST_ACTIVE;
                    if (core_r.tgt == sbpi_pkg::TGT_DRAM) begin
                        core_nxt.cnt = sbpi_pkg::CAS_LAST;
                    end else begin
                        core_nxt.cnt = sbpi_pkg::STROBE_LAST;
                    end
                end else begin
                    core_nxt.cnt = core_r.cnt - 1'b1;
                end
            end
            sbpi_pkg::ST_ACTIVE: begin
                case (core_r.tgt)
                    sbpi_pkg::TGT_LCD: begin
                        finish = (core_r.cnt == '0) && display_card_ready;
                    end
                    sbpi_pkg::TGT_CARD_IO, sbpi_pkg::TGT_CARD_MEM: begin
                        // Zero-wait cuts the strobe short even before the minimum width
                        finish = ((core_r.cnt == '0) && display_card_ready)
                            || !card_no_wait_n;
                    end
                    default: begin
                        finish = (core_r.cnt == '0);
                    end
                endcase
                if (finish) begin
                    core_nxt.st = sbpi_pkg::ST_FINISH;
                    core_nxt.cnt = sbpi_pkg::HOLD_LAST;
                    core_nxt.ackV = 1'b1;
                    if (!core_r.write) begin
                        core_nxt.ackD = busDataIn;
                    end
                end else if (core_r.cnt != '0) begin
                    core_nxt.cnt = core_r.cnt - 1'b1;
                end
            end
            sbpi_pkg::ST_FINISH: begin
                if (core_r.cnt == '0) begin
                    core_nxt.st = sbpi_pkg::ST_IDLE;
                end else begin
                    core_nxt.cnt = core_r.cnt - 1'b1;
                end
            end
            default: begin
                core_nxt.st = sbpi_pkg::ST_IDLE;
            end
        endcase

        // Pins follow the next state so every strobe comes straight from a flop
        inAcc = (core_nxt.st != sbpi_pkg::ST_IDLE);
        strobe = (core_nxt.st == sbpi_pkg::ST_ACTIVE);
        rowPhase = (core_nxt.st == sbpi_pkg::ST_SETUP);
        isDram = inAcc && (core_nxt.tgt == sbpi_pkg::TGT_DRAM);
        isRom = inAcc && (core_nxt.tgt == sbpi_pkg::TGT_ROM);
        isLcd = inAcc && (core_nxt.tgt == sbpi_pkg::TGT_LCD);
        isCio = inAcc && (core_nxt.tgt == sbpi_pkg::TGT_CARD_IO);
        isCmem = inAcc && (core_nxt.tgt == sbpi_pkg::TGT_CARD_MEM);

        core_nxt.rdy = !inAcc;
        if (isDram && rowPhase) begin
            core_nxt.addrOut = core_nxt.addr >> sbpi_pkg::ROW_SHIFT;
        end else if (isDram) begin
            core_nxt.addrOut = core_nxt.addr & sbpi_pkg::COL_MASK;
        end else begin
            core_nxt.addrOut = core_nxt.addr;
        end
        core_nxt.dOut = core_nxt.wdata;
        core_nxt.dOe = inAcc && core_nxt.write;

        core_nxt.dispSelN = !isLcd;
        core_nxt.dispRdN = !(isLcd && strobe && !core_nxt.write);
        core_nxt.shWrN = !((isLcd || isRom) && strobe && core_nxt.write);

        core_nxt.romSelN = isRom ? sbpi_pkg::sbpiSelN(core_nxt.chip) : sbpi_pkg::SEL_NONE;
        core_nxt.romRdN = !(isRom && strobe && !core_nxt.write);

        // Row strobe drops during finish so the DRAM precharges between accesses
        core_nxt.rasN = (isDram && (rowPhase || strobe)) ?
            sbpi_pkg::sbpiSelN(core_nxt.chip) : sbpi_pkg::SEL_NONE;
        core_nxt.ucasN = !(isDram && strobe && core_nxt.be[sbpi_pkg::BE_HI]);
        core_nxt.lcasN = !(isDram && strobe && core_nxt.be[sbpi_pkg::BE_LO]);
        core_nxt.dramWrN = !(isDram && strobe && core_nxt.write);

        core_nxt.shbN = !((isCio || isCmem) && core_nxt.be[sbpi_pkg::BE_HI]);
        core_nxt.ioRdN = !(isCio && strobe && !core_nxt.write);
        core_nxt.ioWrN = !(isCio && strobe && core_nxt.write);
        core_nxt.memRdN = !(isCmem && strobe && !core_nxt.write);
        core_nxt.memWrN = !(isCmem && strobe && core_nxt.write);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_r <= CORE_RESET;
        end else begin
            core_r <= core_nxt;
        end
    end

    // Active-low pins leave the struct unchanged: low means asserted
    assign reqReady = core_r.rdy;
    assign ackValid = core_r.ackV;
    assign ackData = core_r.ackD;
    assign cardIrqReq = core_r.irqReq;
    assign busAddr = core_r.addrOut;
    assign busDataOut = core_r.dOut;
    assign busDataOe = core_r.dOe;
    assign display_select_n = core_r.dispSelN;
    assign display_read_strobe_n = core_r.dispRdN;
    assign shared_write_strobe_n = core_r.shWrN;
    assign boot_mem_select_n = core_r.romSelN;
    assign boot_mem_read_strobe_n = core_r.romRdN;
    assign dram_row_strobe_n = core_r.rasN;
    assign dram_col_strobe_hi_n = core_r.ucasN;
    assign dram_col_strobe_lo_n = core_r.lcasN;
    assign dram_write_strobe_n = core_r.dramWrN;
    assign card_clock_out = core_r.cardClk;
    assign card_high_byte_en_n = core_r.shbN;
    assign card_io_read_n = core_r.ioRdN;
    assign card_io_write_n = core_r.ioWrN;
    assign card_mem_read_n = core_r.memRdN;
    assign card_mem_write_n = core_r.memWrN;
    assign card_reset_out = core_r.cardRst;

endmodule : sbpi_bus_iface

`default_nettype wire

//--- rtl/HANDOVER_unused.sv
// Empty file: holds no code

//--- bench/sbpi_properties.sv
// Concurrent checks on the system bus pins, bound to the top module
`timescale 1ns/1ns
`default_nettype none

module sbpi_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic [2:0] reqTarget,
    input wire logic ackValid,
    input wire logic busDataOe,
    input wire logic display_select_n,
    input wire logic display_read_strobe_n,
    input wire logic shared_write_strobe_n,
    input wire logic display_card_ready,
    input wire logic [sbpi_pkg::SEL_W-1:0] boot_mem_select_n,
    input wire logic boot_mem_read_strobe_n,
    input wire logic [sbpi_pkg::SEL_W-1:0] dram_row_strobe_n,
    input wire logic dram_col_strobe_hi_n,
    input wire logic dram_col_strobe_lo_n,
    input wire logic dram_write_strobe_n,
    input wire logic card_clock_out,
    input wire logic card_io_read_n,
    input wire logic card_io_write_n,
    input wire logic card_mem_read_n,
    input wire logic card_mem_write_n,
    input wire logic card_no_wait_n,
    input wire logic cardIrq,
    input wire logic cardIrqReq,
    input wire logic cardResetReq,
    input wire logic card_reset_out
);
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic cardStb;
    logic lastClk_r;
    logic seen_r;
    logic [3:0] runLen_r;

    assign cardStb = !(card_io_read_n && card_io_write_n && card_mem_read_n && card_mem_write_n);

    // Length of the current card clock phase; the first phase after reset is not judged
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastClk_r <= 1'b0;
            seen_r <= 1'b0;
            runLen_r <= 4'h0;
        end else begin
            lastClk_r <= card_clock_out;
            if (card_clock_out != lastClk_r) begin
                seen_r <= 1'b1;
                runLen_r <= 4'h1;
            end else if (runLen_r != 4'hf) begin
                runLen_r <= runLen_r + 4'h1;
            end
        end
    end

    sequence takeOf(logic [2:0] t);
        reqValid && reqReady && reqTarget == t;
    endsequence

    one_target_a: assert property (
        $countones({!display_select_n, boot_mem_select_n != 4'hf, dram_row_strobe_n != 4'hf,
        cardStb}) <= 1) else $error("two targets selected at once");
    select_onehot_a: assert property (
        $countones(~boot_mem_select_n) <= 1 && $countones(~dram_row_strobe_n) <= 1)
        else $error("more than one chip selected");
    lcd_read_a: assert property (
        !display_read_strobe_n |-> !display_select_n && !busDataOe) else $error("bad display read");
    shared_write_a: assert property (
        !shared_write_strobe_n |-> busDataOe && (!display_select_n || boot_mem_select_n != 4'hf))
        else $error("shared write strobe without target");
    rom_read_a: assert property (
        !boot_mem_read_strobe_n |-> boot_mem_select_n != 4'hf && !busDataOe)
        else $error("bad boot memory read");
    dram_col_a: assert property (
        !(dram_col_strobe_hi_n && dram_col_strobe_lo_n) |-> dram_row_strobe_n != 4'hf)
        else $error("column strobe without row");
    dram_write_a: assert property (
        !dram_write_strobe_n |-> busDataOe && dram_row_strobe_n != 4'hf)
        else $error("bad dram write strobe");
    ready_wait_a: assert property (
        $rose(ackValid) && !display_select_n |-> $past(display_card_ready))
        else $error("display access ended without ready");
    zero_wait_a: assert property (
        cardStb && !card_no_wait_n |=> ackValid) else $error("zero wait not honoured");
    dram_time_a: assert property (takeOf(3'h0) |-> ##13 ackValid)
        else $error("dram access length wrong");
    rom_time_a: assert property (takeOf(3'h1) |-> ##20 ackValid)
        else $error("boot memory access length wrong");
    card_reset_a: assert property (
        1'b1 |=> card_reset_out == $past(cardResetReq)) else $error("card reset not followed");
    irq_capture_a: assert property (
        1'b1 |=> cardIrqReq == $past(cardIrq)) else $error("card interrupt not captured");
    clock_phase_a: assert property (
        seen_r |-> runLen_r <= 4'h8 && (card_clock_out == lastClk_r || runLen_r >= 4'h7))
        else $error("card clock phase out of range");
endmodule : sbpi_properties

`default_nettype wire

//--- bench/sbpi_far_side.sv
// Far side of the bus: memories, display and card answering reads and ready
`timescale 1ns/1ns
`default_nettype none

module sbpi_far_side (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [sbpi_pkg::ADDR_W-1:0] busAddr,
    input wire logic busDataOe,
    input wire logic display_select_n,
    input wire logic display_read_strobe_n,
    input wire logic boot_mem_read_strobe_n,
    input wire logic dram_col_strobe_hi_n,
    input wire logic dram_col_strobe_lo_n,
    input wire logic card_io_read_n,
    input wire logic card_io_write_n,
    input wire logic card_mem_read_n,
    input wire logic card_mem_write_n,
    input wire logic [7:0] readyDelay,
    input wire logic zeroWait,
    output logic [sbpi_pkg::DATA_W-1:0] busDataIn,
    output logic display_card_ready,
    output logic card_no_wait_n
);
    logic [15:0] idle_r;
    logic [7:0] wait_r;
    logic cardBusy;
    logic busy;
    logic rdOn;

    assign cardBusy = !(card_io_read_n && card_io_write_n && card_mem_read_n && card_mem_write_n);
    assign busy = cardBusy || !display_select_n;
    assign rdOn = !busDataOe && (!display_read_strobe_n || !boot_mem_read_strobe_n
        || !card_io_read_n || !card_mem_read_n || !(dram_col_strobe_hi_n && dram_col_strobe_lo_n));
    // A released bus toggles every cycle so stale data can never pass as a read
    assign busDataIn = rdOn ? (busAddr[15:0] ^ 16'ha5c3) : idle_r;
    assign display_card_ready = busy && wait_r >= readyDelay;
    assign card_no_wait_n = !(zeroWait && cardBusy);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_r <= 16'h0f0f;
            wait_r <= 8'h00;
        end else begin
            idle_r <= ~idle_r;
            wait_r <= !busy ? 8'h00 : (wait_r == 8'hff ? wait_r : wait_r + 8'h01);
        end
    end
endmodule : sbpi_far_side

`default_nettype wire

//--- bench/sbpi_bus_iface_tb.sv
// Self-checking bench for the system bus pin interface
`timescale 1ns/1ns
`default_nettype none

module sbpi_bus_iface_tb;
    typedef struct packed {
        logic [2:0] tgt;
        logic wr;
        logic [1:0] chip;
        logic [1:0] be;
        logic [20:0] addr;
        logic [15:0] data;
        logic [7:0] dly;
        logic zw;
        logic [7:0] lo;
        logic [7:0] hi;
    } sbpi_row_s;

    logic sys_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
    logic cardResetReq = 1'b0, cardIrq = 1'b0, zeroWait = 1'b0;
    logic [2:0] reqTarget = 3'h0;
    logic [1:0] reqChip = 2'h0;
    logic [1:0] reqByteEn = 2'h3;
    logic [20:0] reqAddr = 21'h000000;
    logic [15:0] reqData = 16'h0000;
    logic [7:0] readyDelay = 8'h00;
    logic reqReady, ackValid, cardIrqReq, busDataOe, display_select_n, display_read_strobe_n;
    logic shared_write_strobe_n, display_card_ready, boot_mem_read_strobe_n, dram_col_strobe_hi_n;
    logic dram_col_strobe_lo_n, dram_write_strobe_n, card_clock_out, card_high_byte_en_n;
    logic card_io_read_n, card_io_write_n, card_mem_read_n, card_mem_write_n, card_no_wait_n;
    logic card_reset_out, prevClk;
    logic [15:0] ackData, busDataIn, busDataOut;
    logic [20:0] busAddr;
    logic [3:0] boot_mem_select_n, dram_row_strobe_n;
    logic [19:0] curPins;
    int n_mismatch = 0, comparisons = 0, k;

    sbpi_row_s rows [11] = '{
        '{3'h0, 1'b0, 2'h1, 2'h3, 21'h012345, 16'h0000, 8'h00, 1'b0, 8'h0c, 8'h0c},
        '{3'h0, 1'b1, 2'h3, 2'h2, 21'h1fffff, 16'hbeef, 8'h00, 1'b0, 8'h0c, 8'h0c},
        '{3'h0, 1'b0, 2'h0, 2'h1, 21'h000000, 16'h0000, 8'h00, 1'b0, 8'h0c, 8'h0c},
        '{3'h1, 1'b0, 2'h2, 2'h3, 21'h0abcde, 16'h0000, 8'h00, 1'b0, 8'h13, 8'h13},
        '{3'h1, 1'b1, 2'h0, 2'h3, 21'h1f0001, 16'h1234, 8'h00, 1'b0, 8'h13, 8'h13},
        '{3'h2, 1'b0, 2'h0, 2'h3, 21'h000400, 16'h0000, 8'h00, 1'b0, 8'h13, 8'h13},
        '{3'h2, 1'b1, 2'h0, 2'h3, 21'h000402, 16'h5555, 8'h28, 1'b0, 8'h29, 8'h30},
        '{3'h3, 1'b0, 2'h0, 2'h3, 21'h0003f8, 16'h0000, 8'h00, 1'b1, 8'h05, 8'h05},
        '{3'h3, 1'b1, 2'h0, 2'h1, 21'h0003fa, 16'haaaa, 8'h00, 1'b0, 8'h13, 8'h13},
        '{3'h4, 1'b0, 2'h0, 2'h2, 21'h100000, 16'h0000, 8'h1e, 1'b0, 8'h1f, 8'h26},
        '{3'h4, 1'b1, 2'h0, 2'h3, 21'h0ffffe, 16'hc0de, 8'h00, 1'b1, 8'h05, 8'h05}
    };

    sbpi_bus_iface sbpi_bus_iface_i (.*);
    sbpi_far_side sbpi_far_side_i (.*);

    assign curPins = {~dram_row_strobe_n, ~boot_mem_select_n, ~card_high_byte_en_n,
        ~card_mem_write_n, ~card_mem_read_n, ~card_io_write_n, ~card_io_read_n,
        ~dram_col_strobe_lo_n, ~dram_col_strobe_hi_n, ~dram_write_strobe_n,
        ~boot_mem_read_strobe_n, ~shared_write_strobe_n, ~display_read_strobe_n, ~display_select_n};

    always #4 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // Pins a correct access should have pulled low at some point before its answer
    function automatic logic [11:0] expMask(input sbpi_row_s r);
        case (r.tgt)
            3'h0: expMask = {5'h00, r.be[0], r.be[1], r.wr, 4'h0};
            3'h1: expMask = {8'h00, !r.wr, r.wr, 2'h0};
            3'h2: expMask = {9'h000, r.wr, !r.wr, 1'b1};
            3'h3: expMask = {r.be[1], 2'h0, r.wr, !r.wr, 7'h00};
            default: expMask = {r.be[1], r.wr, !r.wr, 9'h000};
        endcase
    endfunction : expMask

    task automatic runRow(input sbpi_row_s r);
        int n;
        logic [20:0] a0;
        logic [19:0] seen;
        logic [15:0] rd;
        @(posedge sys_clk);
        readyDelay <= r.dly;
        zeroWait <= r.zw;
        reqTarget <= r.tgt;
        reqWrite <= r.wr;
        reqChip <= r.chip;
        reqByteEn <= r.be;
        reqAddr <= r.addr;
        reqData <= r.data;
        reqValid <= 1'b1;
        do @(posedge sys_clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        #1;
        a0 = busAddr;
        seen = curPins;
        n = 0;
        while (ackValid !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
            seen |= curPins;
        end
        rd = (r.tgt == 3'h0) ? (r.addr[15:0] & 16'h03ff) : r.addr[15:0];
        check(32'(n >= r.lo && n <= r.hi), 32'h1, "answer time");
        check(32'(a0), (r.tgt == 3'h0) ? 32'(r.addr >> 10) : 32'(r.addr), "address");
        check(32'(seen), {12'h000, (r.tgt == 3'h0) ? 4'h1 << r.chip : 4'h0, (r.tgt == 3'h1) ? 4'h1 << r.chip : 4'h0, expMask(r)}, "pins");
        check(r.wr ? 32'(busDataOut) : 32'(ackData), r.wr ? 32'(r.data) : 32'(rd ^ 16'ha5c3), "data");
        while (reqReady !== 1'b1 && n < 250) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(32'(curPins), 32'h0, "idle pins");
    endtask : runRow

    // The run needs some 1300 cycles; the margin is wide on purpose
    initial begin
        #(8 * 20000);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        check(32'({curPins, busDataOe, card_clock_out, reqReady}), 32'h1, "reset state");
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            runRow(rows[i]);
            $display("test row %0d done", i);
        end
        k = 0;
        prevClk = card_clock_out;
        repeat (1000) begin
            @(posedge sys_clk);
            #1;
            if (card_clock_out !== prevClk) k++;
            prevClk = card_clock_out;
        end
        check(32'(k >= 127 && k <= 129), 32'h1, "card clock toggles");
        $display("test card clock done");
        for (int v = 1; v >= 0; v--) begin
            @(posedge sys_clk);
            cardIrq <= v[0];
            cardResetReq <= v[0];
            repeat (2) @(posedge sys_clk);
            #1;
            check(32'({cardIrqReq, card_reset_out}), v ? 32'h3 : 32'h0, "irq and reset");
        end
        $display("test irq and reset done");
        @(posedge sys_clk);
        reqTarget <= 3'h5;
        reqWrite <= 1'b1;
        reqValid <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(32'({curPins, busDataOe, reqReady}), 32'h1, "bad target");
        @(posedge sys_clk);
        reqTarget <= 3'h0;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        #1;
        check(32'({curPins, busDataOe, reqReady}), 32'h1, "reset mid access");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        runRow(rows[3]);
        $display("test bad target and reset mid access done");
        print_verdict();
    end
endmodule : sbpi_bus_iface_tb

bind sbpi_bus_iface sbpi_properties sbpi_properties_i (.*);

`default_nettype wire
